/* File: decode_timing_consts.vh */
`ifndef DECODE_TIMING_CONSTS_VH
`define DECODE_TIMING_CONSTS_VH

// ****************************************************************
// instruction word fields
// ****************************************************************
`define OPC_HI          15
`define OPC_LO          8
`define ALT_BIT         7
`define ROW_HI          7
`define ROW_LO          4
`define COL_HI          3
`define COL_LO          0

// ****************************************************************
// opcode rows and columns used by the decoder
// ****************************************************************
`define ROW_MISC        4'h0
`define ROW_SHIFT_ALU   4'h1
`define ROW_BRANCH      4'h4
`define ROW_MOVE_BIT    4'h6
`define ROW_BIT         4'h7
`define ROW_IMM_FIRST   4'h8
`define ROW_IMM_LAST    4'hE
`define ROW_MOVE_IMM    4'hF
`define COL_NOP         4'h0
`define COL_SLEEP       4'h1
`define COL_ORC         4'h4
`define COL_CONDITION_CODE_AND_OP        4'h6
`define COL_MOVE_A      4'hC
`define COL_MOVE_B      4'hD
`define COL_HALF        4'h8
`define COL_BITMEM      4'hC

// ****************************************************************
// operation classes
// ****************************************************************
`define CLS_W           4
`define CLS_NOP         4'h0
`define CLS_SLEEP       4'h1
`define CLS_CCR         4'h2
`define CLS_ALU         4'h3
`define CLS_ALU_IMM     4'h4
`define CLS_MOVE        4'h5
`define CLS_BRANCH      4'h6
`define CLS_BIT_REG     4'h7
`define CLS_BIT_MEM     4'h8
`define CLS_OTHER       4'h9

// ****************************************************************
// cycle counts per class
// ****************************************************************
`define CNT_W           4
`define CNT_ZERO        4'h0
`define CNT_ONE         4'h1
`define CNT_TWO         4'h2

// ****************************************************************
// state cost of each cycle type
// ****************************************************************
`define COST_W          8
`define COST_MEM        8'h02
`define COST_INTERNAL   8'h01
`define COST_PERIPH_FAST 8'h02
`define COST_PERIPH_SLOW 8'h03
`define STATES_W        8

`endif

/* File: cycle_count_rom.v */
`timescale 1ns/1ps
`default_nettype none

`include "decode_timing_consts.vh"

// per-class cycle counts, registered so the table behaves like a rom
module cycle_count_rom (
	input  wire                 mclk_i,
	input  wire                 rst_i,
	input  wire [`CLS_W-1:0]    cls_i,
	output reg  [`CNT_W-1:0]    fetch_o,
	output reg  [`CNT_W-1:0]    braddr_o,
	output reg  [`CNT_W-1:0]    stack_o,
	output reg  [`CNT_W-1:0]    byte_o,
	output reg  [`CNT_W-1:0]    word_o,
	output reg  [`CNT_W-1:0]    internal_o,
	output reg                  known_o
);

	// ****************************************************************
	// table read, one cycle latency
	// ****************************************************************
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			fetch_o    <= `CNT_ZERO;
			braddr_o   <= `CNT_ZERO;
			stack_o    <= `CNT_ZERO;
			byte_o     <= `CNT_ZERO;
			word_o     <= `CNT_ZERO;
			internal_o <= `CNT_ZERO;
			known_o    <= 1'b0;
		end else begin
			// defaults: one fetch, nothing else
			fetch_o    <= `CNT_ONE;
			braddr_o   <= `CNT_ZERO;
			stack_o    <= `CNT_ZERO;
			byte_o     <= `CNT_ZERO;
			word_o     <= `CNT_ZERO;
			internal_o <= `CNT_ZERO;
			known_o    <= 1'b1;
			case (cls_i)
				`CLS_NOP, `CLS_SLEEP, `CLS_CCR,
				`CLS_ALU, `CLS_ALU_IMM, `CLS_BIT_REG: begin
					fetch_o <= `CNT_ONE; // [RULE_07]
				end
				`CLS_BRANCH: begin
					fetch_o <= `CNT_TWO; // [RULE_07]
				end
				`CLS_BIT_MEM: begin
					fetch_o <= `CNT_TWO; // [RULE_07]
					byte_o  <= `CNT_ONE; // [RULE_07]
				end
				default: begin
					// counts need the second word; flagged unknown
					known_o <= 1'b0;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

/* File: opcode_timing_decode.v */
// What this block does
// RULE_01: first byte, bits 15..8, selects operation
// RULE_02: bit 7 picks alternate set in shared rows
// RULE_03: push/pop decode exactly as moves
// RULE_04: states are sum of count times cost
// RULE_05: memory cycles cost two, internal one
// RULE_06: peripheral byte access costs two or three
// RULE_07: alu one fetch, bitmem 2+1, branch two
// RULE_08: branch row by low nibble; nop, sleep
`timescale 1ns/1ps
`default_nettype none

`include "decode_timing_consts.vh"

module opcode_timing_decode (
	input  wire                   mclk_i,
	input  wire                   rst_i,
	input  wire                   instr_valid_i,
	input  wire [15:0]            instr_word_i,
	input  wire                   byte_periph_i,
	input  wire                   periph_slow_i,
	output reg                    decode_valid_o,
	output reg  [`CLS_W-1:0]      op_class_o,
	output reg  [7:0]             opcode_o,
	output reg                    alt_set_o,
	output reg  [3:0]             branch_cond_o,
	output reg                    counts_known_o,
	output reg  [`STATES_W-1:0]   exec_states_o
);

	// ****************************************************************
	// decode helpers
	// ****************************************************************

	// class of an opcode byte; alternate bit only matters in bit rows
	function [`CLS_W-1:0] classify;
		input [7:0] opc;
		reg   [3:0] row;
		reg   [3:0] col;
		begin
			row = opc[`ROW_HI:`ROW_LO];
			col = opc[`COL_HI:`COL_LO];
			classify = `CLS_OTHER;
			case (row)
				`ROW_MISC: begin
					if (col == `COL_NOP)
						classify = `CLS_NOP; // [RULE_08]
					else if (col == `COL_SLEEP)
						classify = `CLS_SLEEP; // [RULE_08]
					else if (col >= `COL_ORC && col <= `COL_CONDITION_CODE_AND_OP)
						classify = `CLS_CCR;
					else if (col == `COL_MOVE_A || col == `COL_MOVE_B)
						classify = `CLS_MOVE;
					else if (col >= `COL_HALF)
						classify = `CLS_ALU;
					else
						classify = `CLS_OTHER;
				end
				`ROW_SHIFT_ALU: classify = `CLS_ALU;
				`ROW_BRANCH:    classify = `CLS_BRANCH; // [RULE_08]
				`ROW_MOVE_BIT: begin
					// push/pop share these codes, so no class of their own
					if (col >= `COL_HALF)
						classify = `CLS_MOVE; // [RULE_03]
					else
						classify = `CLS_OTHER;
				end
				`ROW_BIT: begin
					if (col >= `COL_BITMEM)
						classify = `CLS_BIT_MEM;
					else if (col < `COL_HALF)
						classify = `CLS_BIT_REG;
					else
						classify = `CLS_OTHER;
				end
				`ROW_MOVE_IMM: classify = `CLS_MOVE; // [RULE_03]
				default: begin
					if (row >= `ROW_IMM_FIRST && row <= `ROW_IMM_LAST)
						classify = `CLS_ALU_IMM;
					else
						classify = `CLS_OTHER;
				end
			endcase
		end
	endfunction

	// rows where the second byte's top bit picks between two sets
	function shared_row;
		input [7:0] opc;
		begin
			shared_row = (opc[`ROW_HI:`ROW_LO] == `ROW_MOVE_BIT) ||
				(opc[`ROW_HI:`ROW_LO] == `ROW_BIT);
		end
	endfunction

	// count weighted by state cost
	function [`STATES_W-1:0] weigh;
		input [`CNT_W-1:0]  cnt;
		input [`COST_W-1:0] cost;
		begin
			weigh = {{(`STATES_W-`CNT_W){1'b0}}, cnt} * cost;
		end
	endfunction

	// ****************************************************************
	// stage 1: decode
	// ****************************************************************
	wire [7:0]          opc_byte;  // first instruction byte
	wire [`CLS_W-1:0]   next_cls;  // class of the incoming word
	reg                 s1_valid;  // stage 1 holds a word
	reg  [`CLS_W-1:0]   s1_cls;    // stage 1 class
	reg  [7:0]          s1_opc;    // stage 1 opcode byte
	reg                 s1_alt;    // stage 1 alternate set select
	reg                 s1_periph; // byte access goes to a peripheral
	reg                 s1_slow;   // addressed peripheral is slow

	assign opc_byte = instr_word_i[`OPC_HI:`OPC_LO]; // [RULE_01]
	assign next_cls = classify(opc_byte);            // [RULE_01]

	// capture decode with the access target sampled alongside
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_valid  <= 1'b0;
			s1_cls    <= `CLS_NOP;
			s1_opc    <= 8'h00;
			s1_alt    <= 1'b0;
			s1_periph <= 1'b0;
			s1_slow   <= 1'b0;
		end else begin
			s1_valid <= instr_valid_i;
			if (instr_valid_i) begin
				s1_cls    <= next_cls;
				s1_opc    <= opc_byte;
				// only shared rows carry an alternate set
				s1_alt    <= shared_row(opc_byte) &
					instr_word_i[`ALT_BIT]; // [RULE_02]
				s1_periph <= byte_periph_i;
				s1_slow   <= periph_slow_i;
			end
		end
	end

	// ****************************************************************
	// cycle count table
	// ****************************************************************
	wire [`CNT_W-1:0] cnt_fetch;  // instruction fetch cycles
	wire [`CNT_W-1:0] cnt_braddr; // branch address read cycles
	wire [`CNT_W-1:0] cnt_stack;  // stack operation cycles
	wire [`CNT_W-1:0] cnt_byte;   // byte data access cycles
	wire [`CNT_W-1:0] cnt_word;   // word data access cycles
	wire [`CNT_W-1:0] cnt_int;    // internal operation cycles
	wire              cnt_known;  // counts fully known from first word

	// table is read in the same cycle as stage 1 is written
	cycle_count_rom u_rom (
		.mclk_i     (mclk_i),
		.rst_i      (rst_i),
		.cls_i      (next_cls),
		.fetch_o    (cnt_fetch),
		.braddr_o   (cnt_braddr),
		.stack_o    (cnt_stack),
		.byte_o     (cnt_byte),
		.word_o     (cnt_word),
		.internal_o (cnt_int),
		.known_o    (cnt_known)
	);

	// ****************************************************************
	// stage 2: weigh and sum
	// ****************************************************************
	reg [`COST_W-1:0]   byte_cost;   // cost of one byte access
	reg [`STATES_W-1:0] next_states; // weighted total

	// byte cost depends on the target; all else is fixed
	always @* begin
		if (s1_periph) begin
			if (s1_slow)
				byte_cost = `COST_PERIPH_SLOW; // [RULE_06]
			else
				byte_cost = `COST_PERIPH_FAST; // [RULE_06]
		end else begin
			byte_cost = `COST_MEM; // [RULE_05]
		end
		// sum can not overflow: counts here stay tiny
		next_states = weigh(cnt_fetch, `COST_MEM) +
			weigh(cnt_braddr, `COST_MEM) +
			weigh(cnt_stack, `COST_MEM) +
			weigh(cnt_byte, byte_cost) +
			weigh(cnt_word, `COST_MEM) +
			weigh(cnt_int, `COST_INTERNAL); // [RULE_04] [RULE_05]
	end

	// register every output; a bubble keeps the last result
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			decode_valid_o <= 1'b0;
			op_class_o     <= `CLS_NOP;
			opcode_o       <= 8'h00;
			alt_set_o      <= 1'b0;
			branch_cond_o  <= 4'h0;
			counts_known_o <= 1'b0;
			exec_states_o  <= {`STATES_W{1'b0}};
		end else begin
			decode_valid_o <= s1_valid;
			if (s1_valid) begin
				op_class_o     <= s1_cls;
				opcode_o       <= s1_opc;
				alt_set_o      <= s1_alt; // [RULE_02]
				// condition comes straight from the low nibble
				if (s1_cls == `CLS_BRANCH)
					branch_cond_o <= s1_opc[`COL_HI:`COL_LO]; // [RULE_08]
				else
					branch_cond_o <= 4'h0;
				counts_known_o <= cnt_known;
				exec_states_o  <= next_states; // [RULE_04]
			end
		end
	end

endmodule

`default_nettype wire

/* File: periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// far side: on-chip memory or peripheral chosen by data address
// ****************************************************************
module periph_model (
	input  wire logic [7:0] addr_i,
	output var  logic       periph_o,
	output var  logic       slow_o
);
	// top page is peripheral space, its upper half needs the slow access
	always_comb begin
		periph_o = (addr_i[7:4] == 4'hF);
		slow_o   = periph_o & addr_i[3];
	end
endmodule
`default_nettype wire

/* File: opcode_timing_decode_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port checker: every result lands two edges after its word
// ****************************************************************
module opcode_timing_decode_assertions (
	input wire logic        mclk_i,
	input wire logic        rst_i,
	input wire logic        instr_valid_i,
	input wire logic [15:0] instr_word_i,
	input wire logic        byte_periph_i,
	input wire logic        periph_slow_i,
	input wire logic        decode_valid_o,
	input wire logic [3:0]  op_class_o,
	input wire logic [7:0]  opcode_o,
	input wire logic        alt_set_o,
	input wire logic [3:0]  branch_cond_o,
	input wire logic        counts_known_o,
	input wire logic [7:0]  exec_states_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	wire logic [7:0] opc = instr_word_i[15:8]; // first byte
	wire logic       go  = instr_valid_i;

	AST_LAT: assert property (go |-> ##2 decode_valid_o)
		else $error("late");
	AST_IDLE: assert property (!go |-> ##2 !decode_valid_o)
		else $error("extra");
	AST_OPC: assert property (go |-> ##2 opcode_o == $past(opc, 2))
		else $error("opcode");
	AST_ALT: assert property (go && opc[7:5] == 3'b011 |-> ##2
		alt_set_o == $past(instr_word_i[7], 2)) else $error("alt");
	AST_ALT0: assert property (go && opc[7:5] != 3'b011 |-> ##2 !alt_set_o)
		else $error("alt set");
	AST_MOVE: assert property (go && opc[7:1] == 7'h06 |-> ##2
		op_class_o == 4'h5) else $error("move");
	AST_BR: assert property (go && opc[7:4] == 4'h4 |-> ##2
		op_class_o == 4'h6 && exec_states_o == 8'h04 &&
		branch_cond_o == $past(opc[3:0], 2)) else $error("branch");
	AST_NOP: assert property (go && opc == 8'h00 |-> ##2
		op_class_o == 4'h0 && exec_states_o == 8'h02) else $error("nop");
	AST_SLOW: assert property (go && opc[7:2] == 6'h1F && byte_periph_i &&
		periph_slow_i |-> ##2 exec_states_o == 8'h07) else $error("slow");
	AST_ALU: assert property (go && opc[7:4] == 4'h1 |-> ##2
		exec_states_o == 8'h02 && counts_known_o) else $error("alu");
	C_BR: cover property (go && opc[7:4] == 4'h4);
	C_SLOW: cover property (go && byte_periph_i && periph_slow_i);
	C_B2B: cover property (decode_valid_o [*2]);
endmodule
bind opcode_timing_decode opcode_timing_decode_assertions i_chk (
	.mclk_i(mclk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
	.instr_word_i(instr_word_i), .byte_periph_i(byte_periph_i),
	.periph_slow_i(periph_slow_i), .decode_valid_o(decode_valid_o),
	.op_class_o(op_class_o), .opcode_o(opcode_o), .alt_set_o(alt_set_o),
	.branch_cond_o(branch_cond_o), .counts_known_o(counts_known_o),
	.exec_states_o(exec_states_o));
`default_nettype wire

/* File: test_opcode_timing_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module test_opcode_timing_decode;
	logic mclk_i, rst_i, instr_valid_i, byte_periph_i, periph_slow_i;
	logic [15:0] instr_word_i; // word under test
	logic [7:0]  addr;         // data address seen by the far side
	logic dv, alt, kn;
	logic [3:0] cls, cond;
	logic [7:0] opc, st;
	int n_mismatch = 0;
	int check_count = 0;

	opcode_timing_decode i_opcode_timing_decode (.mclk_i(mclk_i),
		.rst_i(rst_i), .instr_valid_i(instr_valid_i),
		.instr_word_i(instr_word_i), .byte_periph_i(byte_periph_i),
		.periph_slow_i(periph_slow_i), .decode_valid_o(dv),
		.op_class_o(cls), .opcode_o(opc), .alt_set_o(alt),
		.branch_cond_o(cond), .counts_known_o(kn), .exec_states_o(st));
	periph_model i_periph_model (.addr_i(addr), .periph_o(byte_periph_i),
		.slow_o(periph_slow_i));

	always #5 mclk_i = ~mclk_i;

	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// one word, result judged the cycle its valid pulse stands
	task automatic run(input logic [15:0] w, input logic [7:0] a,
		input logic [3:0] c, input logic [7:0] s, input logic k);
		@(negedge mclk_i);
		instr_valid_i = 1'b1;
		instr_word_i = w;
		addr = a;
		@(negedge mclk_i);
		instr_valid_i = 1'b0;
		// valid pulse stands between the second and third edge only
		@(negedge mclk_i);
		cmp("valid", 8'h01, {7'h00, dv});
		cmp("class", {4'h0, c}, {4'h0, cls});
		cmp("states", s, st);
		cmp("known", {7'h00, k}, {7'h00, kn});
		cmp("opcode", w[15:8], opc);
	endtask

	task automatic t_alu();
		run(16'h0800, 8'h00, 4'h3, 8'h02, 1'b1);
		run(16'h1000, 8'h00, 4'h3, 8'h02, 1'b1);
		run(16'h8012, 8'h00, 4'h4, 8'h02, 1'b1);
		run(16'h0600, 8'h00, 4'h2, 8'h02, 1'b1);
	endtask
	task automatic t_alt();
		run(16'h7080, 8'h00, 4'h7, 8'h02, 1'b1);
		cmp("alt1", 8'h01, {7'h00, alt});
		run(16'h7000, 8'h00, 4'h7, 8'h02, 1'b1);
		cmp("alt0", 8'h00, {7'h00, alt});
	endtask
	task automatic t_move();
		run(16'h0C12, 8'h00, 4'h5, 8'h02, 1'b0);
		run(16'h0D34, 8'h00, 4'h5, 8'h02, 1'b0);
	endtask
	task automatic t_branch();
		for (int i = 0; i < 16; i++) begin
			run({4'h4, i[3:0], 8'hFE}, 8'h00, 4'h6, 8'h04, 1'b1);
			cmp("cond", {4'h0, i[3:0]}, {4'h0, cond});
		end
	endtask
	task automatic t_nop();
		run(16'h0000, 8'h00, 4'h0, 8'h02, 1'b1);
		run(16'h0100, 8'h00, 4'h1, 8'h02, 1'b1);
	endtask
	// bit op on memory: two fetches plus one byte access
	task automatic t_bitmem();
		run(16'h7C00, 8'h00, 4'h8, 8'h06, 1'b1);
		run(16'h7D00, 8'hF0, 4'h8, 8'h06, 1'b1);
		run(16'h7F00, 8'hF8, 4'h8, 8'h07, 1'b1);
	endtask
	task automatic t_b2b();
		@(negedge mclk_i);
		instr_valid_i = 1'b1;
		instr_word_i = 16'h4000;
		addr = 8'h00;
		@(negedge mclk_i);
		instr_word_i = 16'h0000;
		@(negedge mclk_i);
		instr_valid_i = 1'b0;
		cmp("b2b0", 8'h04, st);
		@(negedge mclk_i);
		cmp("b2b1", 8'h00, opc);
		cmp("b2bv", 8'h01, {7'h00, dv});
		cmp("b2bs", 8'h02, st);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog well beyond the roughly 30 words of traffic
	initial begin
		#50000;
		n_mismatch++;
		stop_test();
	end

	initial begin
		mclk_i = 1'b0;
		rst_i = 1'b1;
		instr_valid_i = 1'b0;
		instr_word_i = 16'h0000;
		addr = 8'h00;
		repeat (16) @(negedge mclk_i);
		cmp("rst", 8'h00, st);
		rst_i = 1'b0;
		t_alu();
		t_alt();
		t_move();
		t_branch();
		t_nop();
		t_bitmem();
		t_b2b();
		stop_test();
	end
endmodule
`default_nettype wire
